/* pkg/ccp_regs.svh */
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH
// Register byte addresses on the bus
`define OFF_UNIT_CONTROL     32'h0000_0000
`define OFF_VALUE_LOW_BYTE   32'h0000_0004
`define OFF_VALUE_HIGH_BYTE  32'h0000_0008
`define OFF_CAPTURE_TRIGGER  32'h0000_000C
`define OFF_TIMEBASE_SEL_ONE 32'h0000_0010
// Control register fields
`define CTRL_EN_BIT  7
`define CTRL_OUT_BIT 5
`define CTRL_FMT_BIT 4
// Reset values
`define RST_BYTE     8'h00
`define RST_NIBBLE   4'h0
// Mode encodings
`define MODE_OFF          4'h0
`define MODE_TOGGLE_CLEAR 4'h1
`define MODE_TOGGLE       4'h2
`define MODE_CAP_BOTH     4'h3
`define MODE_CAP_FALL     4'h4
`define MODE_CAP_RISE     4'h5
`define MODE_CAP_RISE4    4'h6
`define MODE_CAP_RISE16   4'h7
`define MODE_CMP_SET      4'h8
`define MODE_CMP_CLEAR    4'h9
`define MODE_PULSE        4'hA
`define MODE_PULSE_CLEAR  4'hB
`define MODE_PWM_TOP      2'h3
// Capture prescale terminal counts
`define PRESCALE_4_LAST   4'h3
`define PRESCALE_16_LAST  4'hF
// Bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

/* pkg/ccp_pkg.sv */
package ccp_pkg;
	`include "ccp_regs.svh"
	typedef logic [7:0] byte_t;
	typedef logic [9:0] duty_t;
	typedef logic [3:0] mode_t;
endpackage

/* src/capture_compare_pwm_control.sv */
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - PWM frequency derives from the system clock; no other clock is used.
// - Any reset returns every register to reset value and releases the pin.
// - The PWM output is offered to converters, generators, logic and pins.
// - Control bit 7 enables the unit; bit 6 reads zero.
// - Control bit 5 is read-only and shows the live output level.
// - Alignment bit 4 picks left (1) or right (0) duty alignment.
// - Mode field selects function; 11xx is PWM; 0000 off and resets state.
// - Mode 1011 pulses output and clears the 16-bit timer on match.
// - Mode 1010 gives one low-high-low pulse on match, timer keeps running.
// - Mode 1001 sets output on selection and clears it on match.
// - Mode 1000 sets output on selection and sets it on match.
// - Modes 0111 and 0110 capture every 16th and 4th rising edge.
// - Modes 0101, 0100, 0011 capture on rising, falling, either edge.
// - Mode 0010 toggles output on match, timer keeps running.
// - Mode 0001 toggles output and clears the timer on match.
// - Capture loads timer low and high bytes into the value registers.
// - Compare uses high:low value registers as the 16-bit match value.
// - Right aligned: low gives duty 7:0, high 1:0 gives duty 9:8.
// - Left aligned: high gives duty 9:2, low 7:6 gives duty 1:0.
// - Trigger select picks pin-change, logic cell, comparator or remap pin.
// - Each unit picks one of four period timers by a 2-bit field.
// - Timebase register packs fields for units 8, 7, 2, 1 from the top.
// - At period end the duty latches and output sets unless duty is zero.
// - Output clears when the 10-bit time base equals the latched duty.
// - Duty registers are double buffered, taking effect at period end.
module capture_compare_pwm_control import ccp_pkg::*; #(
	parameter int UNIT_SLOT = 0
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] free_running_16bit_timer,
	output logic             timer_clear,
	input  wire logic [31:0] period_timer_count,
	input  wire logic [31:0] period_timer_value,
	input  wire logic [7:0]  period_timer_phase,
	input  wire logic        pin_change_event,
	input  wire logic [3:0]  logic_cell_output,
	input  wire logic [7:0]  comparator_synced_output,
	input  wire logic        pin_remap_select,
	output logic             unit_out,
	output logic             pin_oe_n
);
	import ccp_pkg::*;

	if (UNIT_SLOT < 0 || UNIT_SLOT > 3) begin
		$error("UNIT_SLOT must be 0 to 3");
	end

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic        ctrl_en;
	logic        ctrl_fmt;
	mode_t       ctrl_mode;
	byte_t       value_low_byte;
	byte_t       value_high_byte;
	logic [3:0]  capture_trigger_select;
	byte_t       timebase_select_one;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one write and one read at a time
	logic [31:0] aw_addr_q;
	logic        aw_held;
	logic [31:0] w_data_q;
	logic        w_strb0_q;
	logic        w_held;
	wire         aw_take  = s_axi_awvalid && s_axi_awready;
	wire         w_take   = s_axi_wvalid && s_axi_wready;
	wire         do_write = aw_held && w_held && !s_axi_bvalid;
	wire         ar_take  = s_axi_arvalid && s_axi_arready;

	// Address decode for writes and reads
	wire wr_ctrl = aw_addr_q == `OFF_UNIT_CONTROL;
	wire wr_low  = aw_addr_q == `OFF_VALUE_LOW_BYTE;
	wire wr_high = aw_addr_q == `OFF_VALUE_HIGH_BYTE;
	wire wr_cap  = aw_addr_q == `OFF_CAPTURE_TRIGGER;
	wire wr_tsel = aw_addr_q == `OFF_TIMEBASE_SEL_ONE;
	wire wr_hit  = wr_ctrl || wr_low || wr_high || wr_cap || wr_tsel;
	wire wr_lane = do_write && w_strb0_q;
	wire rd_ctrl = s_axi_araddr == `OFF_UNIT_CONTROL;
	wire rd_low  = s_axi_araddr == `OFF_VALUE_LOW_BYTE;
	wire rd_high = s_axi_araddr == `OFF_VALUE_HIGH_BYTE;
	wire rd_cap  = s_axi_araddr == `OFF_CAPTURE_TRIGGER;
	wire rd_tsel = s_axi_araddr == `OFF_TIMEBASE_SEL_ONE;
	wire rd_hit  = rd_ctrl || rd_low || rd_high || rd_cap || rd_tsel;

	// Control readback: bit 6 unimplemented, bit 5 live output
	wire byte_t ctrl_rd = {ctrl_en, 1'b0, unit_out, ctrl_fmt, ctrl_mode};
	wire byte_t rd_byte = rd_ctrl ? ctrl_rd :
		rd_low  ? value_low_byte :
		rd_high ? value_high_byte :
		rd_cap  ? {4'h0, capture_trigger_select} :
		rd_tsel ? timebase_select_one : `RST_BYTE;

	// Write channels are held until both have arrived
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_q     <= 32'h0000_0000;
			w_data_q      <= 32'h0000_0000;
			w_strb0_q     <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held       <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_held       <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb0_q    <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read answers one cycle after the address is taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_byte};
			s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trigger selection and synchroniser
	logic        trig_meta;
	logic        trig_sync;
	logic        trig_q;
	// Codes 14 and 15 select nothing and read as a steady low
	wire [15:0]  trig_vec = {2'b00, pin_change_event, logic_cell_output,
		comparator_synced_output, pin_remap_select};
	wire         trig_raw  = trig_vec[capture_trigger_select];
	wire         trig_rise = trig_sync && !trig_q;
	wire         trig_fall = !trig_sync && trig_q;

	// Two flops before any edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trig_meta <= 1'b0;
			trig_sync <= 1'b0;
			trig_q    <= 1'b0;
		end else begin
			trig_meta <= trig_raw;
			trig_sync <= trig_meta;
			trig_q    <= trig_sync;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire        active    = ctrl_en && (ctrl_mode != `MODE_OFF);
	wire        is_pwm    = ctrl_mode[3:2] == `MODE_PWM_TOP;
	wire [15:0] cmp_value = {value_high_byte, value_low_byte};
	logic       match_seen;
	mode_t      mode_q;
	// Act once per match so a slow timer does not retrigger every clock
	wire        match_now  = free_running_16bit_timer == cmp_value;
	wire        match_edge = active && match_now && !match_seen;
	wire        entered    = mode_q != ctrl_mode;

	////////////////////////////////////////////////////////////////////////
	// Capture event selection and prescale
	logic [3:0] prescale;
	wire        ps_last4  = prescale == `PRESCALE_4_LAST;
	wire        ps_last16 = prescale == `PRESCALE_16_LAST;
	logic       cap_event;
	always_comb begin
		cap_event = 1'b0;
		if (active) begin
			case (ctrl_mode)
				`MODE_CAP_RISE16: cap_event = trig_rise && ps_last16;
				`MODE_CAP_RISE4:  cap_event = trig_rise && ps_last4;
				`MODE_CAP_RISE:   cap_event = trig_rise;
				`MODE_CAP_FALL:   cap_event = trig_fall;
				`MODE_CAP_BOTH:   cap_event = trig_rise || trig_fall;
				default:          cap_event = 1'b0;
			endcase
		end
	end

	// Prescale counts rising edges; restarts when the mode changes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescale <= `RST_NIBBLE;
		end else if (!active || entered) begin
			prescale <= `RST_NIBBLE;
		end else if (trig_rise) begin
			prescale <= (ctrl_mode == `MODE_CAP_RISE4 && ps_last4) ? `RST_NIBBLE
				: prescale + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pulse-width path
	localparam int SEL_LSB = 2 * UNIT_SLOT;
	// Field 11 picks the first timer, so the index is the inverted field
	wire [1:0]  tb_field = timebase_select_one[SEL_LSB +: 2];
	wire [1:0]  tb_idx   = ~tb_field;
	wire byte_t pt_count = period_timer_count[8*tb_idx +: 8];
	wire byte_t pt_value = period_timer_value[8*tb_idx +: 8];
	wire [1:0]  pt_phase = period_timer_phase[2*tb_idx +: 2];
	wire duty_t tb10     = {pt_count, pt_phase};
	wire duty_t duty_reg = ctrl_fmt ? {value_high_byte, value_low_byte[7:6]}
		: {value_high_byte[1:0], value_low_byte};
	byte_t      pt_prev;
	duty_t      duty_latch;
	// Next increment after count equalled period marks the boundary
	wire        boundary = (pt_prev == pt_value) && (pt_count != pt_prev);

	// Duty latch is the second buffer behind the value registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pt_prev    <= `RST_BYTE;
			duty_latch <= 10'h000;
		end else begin
			pt_prev <= pt_count;
			if (!active) begin
				duty_latch <= 10'h000;
			end else if (is_pwm && boundary) begin
				duty_latch <= duty_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output level for every mode
	logic next_out;
	always_comb begin
		next_out = unit_out;
		if (!active) begin
			next_out = 1'b0;
		end else if (is_pwm) begin
			if (boundary) begin
				next_out = duty_reg != 10'h000;
			end else if (tb10 == duty_latch) begin
				next_out = 1'b0;
			end
		end else begin
			case (ctrl_mode)
				`MODE_CMP_SET: next_out = entered || match_edge || unit_out;
				`MODE_CMP_CLEAR: next_out = entered || (unit_out && !match_edge);
				`MODE_PULSE, `MODE_PULSE_CLEAR: next_out = match_edge;
				`MODE_TOGGLE, `MODE_TOGGLE_CLEAR: next_out = unit_out ^ match_edge;
				default: next_out = 1'b0;
			endcase
		end
	end
	wire next_clear = match_edge && (ctrl_mode == `MODE_PULSE_CLEAR ||
		ctrl_mode == `MODE_TOGGLE_CLEAR);

	// Registered outputs; unit_out feeds every internal consumer and pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			unit_out    <= 1'b0;
			timer_clear <= 1'b0;
			pin_oe_n    <= 1'b1;
			match_seen  <= 1'b0;
			mode_q      <= `MODE_OFF;
		end else begin
			unit_out    <= next_out;
			timer_clear <= next_clear;
			pin_oe_n    <= !active;
			match_seen  <= active && match_now;
			// Off reads as no mode, so enabling a set-on-select mode is an entry too
			mode_q      <= active ? ctrl_mode : `MODE_OFF;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers; a capture beats a same-cycle software write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_en                <= 1'b0;
			ctrl_fmt               <= 1'b0;
			ctrl_mode              <= `MODE_OFF;
			value_low_byte         <= `RST_BYTE;
			value_high_byte        <= `RST_BYTE;
			capture_trigger_select <= `RST_NIBBLE;
			timebase_select_one    <= `RST_BYTE;
		end else begin
			if (wr_lane && wr_ctrl) begin
				ctrl_en   <= w_data_q[`CTRL_EN_BIT];
				ctrl_fmt  <= w_data_q[`CTRL_FMT_BIT];
				ctrl_mode <= w_data_q[3:0];
			end
			if (wr_lane && wr_cap) begin
				capture_trigger_select <= w_data_q[3:0];
			end
			if (wr_lane && wr_tsel) begin
				timebase_select_one <= w_data_q[7:0];
			end
			if (cap_event) begin
				value_low_byte  <= free_running_16bit_timer[7:0];
				value_high_byte <= free_running_16bit_timer[15:8];
			end else begin
				if (wr_lane && wr_low) begin
					value_low_byte <= w_data_q[7:0];
				end
				if (wr_lane && wr_high) begin
					value_high_byte <= w_data_q[7:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_bit6_zero: assert property (ar_take && rd_ctrl |=> !s_axi_rdata[6])
		else $error("control bit 6 read as one");
	chk_out_readback: assert property (ar_take && rd_ctrl |=>
		s_axi_rdata[`CTRL_OUT_BIT] == $past(unit_out))
		else $error("output bit does not match output level");
	chk_off_state: assert property (!active |=> !unit_out && pin_oe_n)
		else $error("unit drives output while off");
	chk_toggle_match: assert property (match_edge && ctrl_mode == `MODE_TOGGLE
		&& ctrl_en && !entered |=> unit_out != $past(unit_out))
		else $error("toggle mode missed a match");
	chk_pulse_width: assert property (match_edge && ctrl_mode == `MODE_PULSE && !entered
		|=> unit_out ##1 !unit_out)
		else $error("pulse mode pulse not one cycle");
	chk_timer_clear: assert property (match_edge && (ctrl_mode == `MODE_TOGGLE_CLEAR ||
		ctrl_mode == `MODE_PULSE_CLEAR) |=> timer_clear)
		else $error("timer not cleared on match");
	chk_no_clear_keep: assert property (match_edge && ctrl_mode == `MODE_TOGGLE
		|=> !timer_clear)
		else $error("timer cleared in running toggle mode");
	chk_capture_value: assert property (cap_event |=>
		{value_high_byte, value_low_byte} == $past(free_running_16bit_timer))
		else $error("captured value wrong");
	chk_cmp_clear_sel: assert property (active && ctrl_mode == `MODE_CMP_CLEAR && entered
		|=> unit_out)
		else $error("clear-on-match mode did not set on selection");
	chk_pwm_boundary: assert property (active && is_pwm && boundary
		|=> duty_latch == $past(duty_reg) && unit_out == ($past(duty_reg) != 10'h000))
		else $error("period boundary did not latch duty or set output");
	chk_pwm_clear: assert property (active && is_pwm && !boundary && tb10 == duty_latch
		|=> !unit_out)
		else $error("output not cleared at duty match");

	cov_capture16: cover property (cap_event && ctrl_mode == `MODE_CAP_RISE16);
	cov_pwm_period: cover property (is_pwm && boundary ##[1:600] tb10 == duty_latch);
	cov_toggle_clear: cover property (next_clear && ctrl_mode == `MODE_TOGGLE_CLEAR);
	cov_bus_error: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule

/* sim/ccp_far_side.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Far side: free-running 16-bit timer and four period timers
module ccp_far_side (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic        restart,
	input  wire logic        timer_clear,
	input  wire logic [31:0] period_timer_value,
	output logic [15:0]      free_running_16bit_timer,
	output logic [31:0]      period_timer_count,
	output logic [7:0]       period_timer_phase
);
	logic [1:0] phase;

	// One shared clock phase, prescale 1:1 on every time base
	assign period_timer_phase = {4{phase}};

	// Clear beats counting; run low freezes it so captures are exact
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			free_running_16bit_timer <= 16'h0000;
		else if (timer_clear || restart)
			free_running_16bit_timer <= 16'h0000;
		else if (run)
			free_running_16bit_timer <= free_running_16bit_timer + 16'h0001;
	end

	// Period timers step every fourth clock, reload after their period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 2'h0;
			period_timer_count <= 32'h0000_0000;
		end else begin
			phase <= phase + 2'h1;
			for (int k = 0; k < 4; k++) begin
				if (phase == 2'h3)
					period_timer_count[8*k+:8] <=
						(period_timer_count[8*k+:8] == period_timer_value[8*k+:8]) ? 8'h00
						: period_timer_count[8*k+:8] + 8'h01;
			end
		end
	end
endmodule

/* sim/tb_capture_compare_pwm_control.sv */
`timescale 1ns/1ps
module tb_capture_compare_pwm_control;
	logic        clk, rst, run, restart, lvl;
	logic [3:0]  tsel, s_axi_wstrb, logic_cell_output;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, timer_clear, unit_out, pin_oe_n;
	logic        pin_change_event, pin_remap_select;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] free_running_16bit_timer, capd, tr, tf;
	logic [31:0] period_timer_count, period_timer_value;
	logic [7:0]  period_timer_phase, comparator_synced_output;
	int          err_count, cmp_count, hi, lo, clr;
	// Bus rows: resp, strobe, address, write data, read-back
	logic [31:0] regs [7] = '{32'h0F007F1F, 32'h0F04A5A5, 32'h0F083C3C, 32'h0F0CFD0D,
		32'h0F10E4E4, 32'h000411A5, 32'h2F145500};
	// Compare rows: mode, output at end, single pulse, clears, timer ran on
	logic [7:0]  cmps [6] = '{8'h29, 8'h1A, 8'hB6, 8'hA5, 8'h91, 8'h89};
	// Width rows: format, high, low, timer field, high time, period
	logic [39:0] pwms [5] = '{40'h0FC0A30A28, 40'h102BF30A28, 40'h0000700714,
		40'h0000C20C1C, 40'h0000510518};

	capture_compare_pwm_control #(.UNIT_SLOT(0)) dut (
		.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .free_running_16bit_timer,
		.timer_clear, .period_timer_count, .period_timer_value, .period_timer_phase,
		.pin_change_event, .logic_cell_output, .comparator_synced_output,
		.pin_remap_select, .unit_out, .pin_oe_n
	);
	ccp_far_side far (
		.clk, .rst, .run, .restart, .timer_clear, .period_timer_value,
		.free_running_16bit_timer, .period_timer_count, .period_timer_phase
	);

	// Unselected sources run inverted, so a wrong pick sees the wrong edge
	assign pin_remap_select = lvl ^ (tsel != 4'h0);
	assign comparator_synced_output = {8{lvl}} ^ ~(8'h01 << (tsel - 4'h1));
	assign logic_cell_output = {4{lvl}} ^ ~(4'h1 << (tsel - 4'h9));
	assign pin_change_event = lvl ^ (tsel != 4'hD);

	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic tally_and_finish;
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, d, input logic [3:0] s = 4'hF);
		int n;
		@(posedge clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		rdv = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic chk_reset;
		for (int a = 0; a < 5; a++) begin
			rd(8'(a * 4));
			chk("rst_reg", rdv, 0);
		end
	endtask

	task automatic capv;
		rd(8'h04);
		capd[7:0] = rdv[7:0];
		rd(8'h08);
		capd[15:8] = rdv[7:0];
	endtask

	// Timer frozen around each edge so the captured value is exact
	task automatic cap_pulse;
		@(posedge clk) run <= 1'b0;
		@(posedge clk) lvl <= 1'b1;
		tr = free_running_16bit_timer;
		repeat (8) @(posedge clk);
		run <= 1'b1;
		repeat (5) @(posedge clk);
		run <= 1'b0;
		@(posedge clk) lvl <= 1'b0;
		tf = free_running_16bit_timer;
		repeat (8) @(posedge clk);
		run <= 1'b1;
	endtask

	task automatic wait_lvl(input logic v, output int c);
		c = 0;
		while (unit_out !== v && c < 300) begin
			@(posedge clk);
			c++;
		end
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Bound on the whole run; a hang counts as a mismatch
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end

	initial begin
		{rst, run, restart, lvl, tsel, s_axi_wstrb} = 12'hC0F;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		period_timer_value = 32'h0405_0609;
		repeat (20) @(posedge clk);
		chk("oe_rst", 32'(pin_oe_n), 1);
		chk("out_rst", 32'(unit_out), 0);
		rst <= 1'b0;
		chk_reset;
		foreach (regs[i]) begin
			wr(regs[i][23:16], regs[i][15:8], regs[i][27:24]);
			chk("wresp", 32'(resp), 32'(regs[i][29:28]));
			rd(regs[i][23:16]);
			chk("rresp", 32'(resp), 32'(regs[i][29:28]));
			chk("rdata", rdv, {24'h0, regs[i][7:0]});
		end
		// Compare modes against 0x0040 from a freshly cleared timer
		wr(8'h04, 8'h40);
		wr(8'h08, 8'h00);
		foreach (cmps[i]) begin
			wr(8'h00, 8'h00);
			wr(8'h00, {4'h8, cmps[i][7:4]});
			@(posedge clk) restart <= 1'b1;
			@(posedge clk) restart <= 1'b0;
			hi = 0;
			clr = 0;
			repeat (90) begin
				@(posedge clk);
				hi += unit_out;
				clr += timer_clear;
			end
			chk("out", 32'(unit_out), 32'(cmps[i][3]));
			chk("pulse", 32'(hi == 1), 32'(cmps[i][2]));
			chk("clear", clr, 32'(cmps[i][1]));
			chk("runon", 32'(free_running_16bit_timer > 16'h0040), 32'(cmps[i][0]));
			rd(8'h00);
			chk("ctrl", rdv, {24'h0, 2'b10, cmps[i][3], 1'b0, cmps[i][7:4]});
			chk("oe", 32'(pin_oe_n), 0);
		end
		// Disabled, then enabled, then mode off: pin released when idle
		wr(8'h00, 8'h08);
		repeat (3) @(posedge clk);
		chk("en_off", 32'({unit_out, pin_oe_n}), 1);
		wr(8'h00, 8'h88);
		repeat (3) @(posedge clk);
		chk("en_on", 32'({unit_out, pin_oe_n}), 2);
		wr(8'h00, 8'h80);
		repeat (3) @(posedge clk);
		chk("mode_off", 32'({unit_out, pin_oe_n}), 1);
		// Rising-edge capture from every trigger source
		wr(8'h00, 8'h85);
		for (int c = 0; c < 14; c++) begin
			@(posedge clk) tsel <= 4'(c);
			wr(8'h0C, 8'(c));
			cap_pulse;
			capv;
			chk("cap_src", 32'(capd), 32'(tr));
		end
		wr(8'h00, 8'h84);
		cap_pulse;
		capv;
		chk("cap_fall", 32'(capd), 32'(tf));
		wr(8'h00, 8'h83);
		cap_pulse;
		capv;
		chk("cap_both", 32'(capd), 32'(tf));
		// Prescaled capture: nothing before the fourth or sixteenth edge
		for (int i = 0; i < 2; i++) begin
			wr(8'h00, 8'h00);
			wr(8'h04, 8'h00);
			wr(8'h08, 8'h00);
			wr(8'h00, 8'h86 + 8'(i));
			repeat ((4 << (2 * i)) - 1) cap_pulse;
			capv;
			chk("pre_wait", 32'(capd), 0);
			cap_pulse;
			capv;
			chk("pre_hit", 32'(capd), 32'(tr));
		end
		// Width and period, both alignments, every timer field
		foreach (pwms[i]) begin
			wr(8'h10, {6'h0, pwms[i][17:16]});
			wr(8'h04, pwms[i][27:20]);
			wr(8'h08, pwms[i][35:28]);
			wr(8'h00, {3'b100, pwms[i][36], 2'b11, 2'(i)});
			repeat (100) @(posedge clk);
			wait_lvl(1'b0, hi);
			wait_lvl(1'b1, hi);
			wait_lvl(1'b0, hi);
			wait_lvl(1'b1, lo);
			chk("pw_high", hi, {24'h0, pwms[i][15:8]});
			chk("pw_period", hi + lo, {24'h0, pwms[i][7:0]});
		end
		wr(8'h04, 8'h00);
		repeat (60) @(posedge clk);
		wait_lvl(1'b1, hi);
		chk("zero_duty", hi, 300);
		// Second reset in mid-run
		wr(8'h04, 8'h05);
		repeat (40) @(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("oe_rst2", 32'(pin_oe_n), 1);
		chk("out_rst2", 32'(unit_out), 0);
		rst <= 1'b0;
		chk_reset;
		tally_and_finish;
	end
endmodule
